// File: verification/dcc_mem_model.sv
// Data RAM and peripheral responder for the DMA engine
`timescale 1ns/1ps
module dcc_mem_model (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic slow_i,
   input wire logic req_i,
   input wire logic [31:0] addr_i,
   output logic ack_o,
   output logic [15:0] rdata_o
);
   logic [1:0] wait_r;
   // Acknowledge each phase once, at once or after three stall cycles
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wait_r <= 2'h0;
         ack_o <= 1'b0;
      end else begin
         ack_o <= req_i && !ack_o && (!slow_i || wait_r == 2'h3);
         wait_r <= (req_i && !ack_o) ? wait_r + 2'h1 : 2'h0;
      end
   end
   // Data only valid with ack, scrambled otherwise
   assign rdata_o = ack_o ? addr_i[15:0] ^ 16'h5A3C : ~(addr_i[15:0] ^ 16'h5A3C);
endmodule : dcc_mem_model

// File: verification/dcc_top_monitor.sv
// Concurrent checks on the ports of the DMA controller
`timescale 1ns/1ps
module dcc_top_monitor (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic mem_req_o,
   input wire logic mem_we_o,
   input wire logic mem_periph_o,
   input wire logic [31:0] mem_addr_o,
   input wire logic [15:0] mem_wdata_o,
   input wire logic mem_byte_o,
   input wire logic mem_ack_i,
   input wire logic irq_o
);
   logic [3:0] idle_r;
   logic [3:0] idle_nxt;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   // Cycles since the last phase acknowledge, held at 15
   always_comb begin
      idle_nxt = mem_ack_i ? 4'h0 : idle_r + {3'h0, idle_r != 4'hF};
   end
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         idle_r <= 4'hF;
      end else begin
         idle_r <= idle_nxt;
      end
   end
   sequence s_rd_done;
      mem_req_o && !mem_we_o && mem_ack_i;
   endsequence
   sequence s_wr_done;
      mem_req_o && mem_we_o && mem_ack_i;
   endsequence
   property p_wait_first;
      $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o;
   endproperty
   a_wait_first: assert property (p_wait_first) else $error("no wait state");
   property p_wait_end;
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   a_wait_end: assert property (p_wait_end) else $error("wait too long");
   property p_wait_idle;
      !(avs_read_i || avs_write_i) |-> !avs_waitrequest_o;
   endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("wait without request");
   property p_unmapped;
      avs_read_i && !avs_waitrequest_o && avs_address_i >= 8'hA0 |-> avs_readdata_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_hold;
      mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_byte_o);
   endproperty
   a_hold: assert property (p_hold) else $error("phase changed before ack");
   property p_swap;
      s_rd_done |=> mem_we_o && mem_periph_o != $past(mem_periph_o);
   endproperty
   a_swap: assert property (p_swap) else $error("write not on other bus");
   property p_null;
      s_wr_done ##1 (mem_req_o && mem_we_o) |-> mem_periph_o && mem_wdata_o == 16'h0000;
   endproperty
   a_null: assert property (p_null) else $error("extra write not null");
   property p_irq_src;
      $rose(irq_o) |-> idle_r < 4'h5 || $past(avs_write_i);
   endproperty
   a_irq_src: assert property (p_irq_src) else $error("interrupt without cause");
   property p_rst_quiet;
      $rose(rstn_i) |-> !mem_req_o && !irq_o;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
endmodule : dcc_top_monitor
bind dcc_top dcc_top_monitor dcc_top_monitor_i (.*);

// File: verification/test_dma_channel_control.sv
// Self-checking bench of the four-channel DMA controller
`timescale 1ns/1ps
module test_dma_channel_control;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] avs_address_i = 8'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0000_0000;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic [7:0] periph_req_i = 8'h00;
   logic mem_req_o, mem_we_o, mem_periph_o, mem_byte_o, mem_ack_i, irq_o;
   logic [31:0] mem_addr_o;
   logic [15:0] mem_wdata_o, mem_rdata_i, rd_last;
   logic slow = 1'b0;
   logic dir = 1'b0;
   logic byt = 1'b0;
   logic nul = 1'b0;
   logic [15:0] bm;
   logic [31:0] seed = 32'h0b74_4b86;
   logic [31:0] q, s;
   logic [15:0] pa;
   logic [31:0] msk [6] = '{32'h0000_7833, 32'h0000_00FF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
      32'h0000_FFFF, 32'h0000_3FFF};
   int bad_count = 0;
   int comparisons = 0;
   // Clock of 20 ns
   always #10 clk_i = ~clk_i;
   dcc_top dcc_top_i (.*);
   dcc_mem_model dcc_mem_model_i (.clk_i(clk_i), .rstn_i(rstn_i), .slow_i(slow),
      .req_i(mem_req_o), .addr_i(mem_addr_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
   assign bm = byt ? 16'h00FF : 16'hFFFF;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // Last RAM address of a block of n+1 transfers
   function automatic logic [31:0] ram_end(input logic [31:0] b, input logic [31:0] n,
      input logic inc, input logic w8);
      return inc ? b + (w8 ? n : n << 1) : b;
   endfunction : ram_end
   task automatic complete_run();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp
   task automatic hang();
      bad_count++;
      complete_run();
   endtask : hang
   // One Avalon cycle, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= !w;
      for (int n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (avs_waitrequest_o === 1'b0) break;
      end
      if (avs_waitrequest_o !== 1'b0) hang();
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      cmp(q, e);
   endtask : rdc
   // One request pulse, then wait for the engine to finish it
   task automatic xfer(input int k);
      periph_req_i[k] <= 1'b1;
      @(posedge clk_i);
      periph_req_i[k] <= 1'b0;
      for (int n = 0; n < 8 && mem_req_o !== 1'b1; n++) @(posedge clk_i);
      if (mem_req_o !== 1'b1) hang();
      for (int n = 0; n < 60 && mem_req_o !== 1'b0; n++) @(posedge clk_i);
      if (mem_req_o !== 1'b0) hang();
      @(posedge clk_i);
   endtask : xfer
   // Data and direction of every acknowledged phase
   always @(posedge clk_i) begin
      if (mem_req_o === 1'b1 && mem_ack_i === 1'b1) begin
         if (mem_periph_o === 1'b1) cmp(mem_addr_o, {16'h0000, pa});
         if (!mem_we_o) begin
            rd_last <= mem_rdata_i;
            cmp(32'(mem_periph_o), 32'(!dir));
         end else if (nul && mem_periph_o) begin
            cmp(32'(mem_wdata_o), 32'h0000_0000);
         end else begin
            cmp(32'(mem_periph_o), 32'(dir));
            cmp(32'(mem_byte_o), 32'(byt));
            cmp(32'(mem_wdata_o & bm), 32'(rd_last & bm));
         end
      end
   end
   // Main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      rdc(8'h9C, 32'h0000_4444);
      rdc(8'h8C, 32'h0000_000F);
      rdc(8'hA4, 32'h0000_0000);
      for (int c = 0; c < 4; c++) begin
         s = rnd();
         for (int r = 0; r < 6; r++) begin
            bus(1'b1, 8'(c * 32 + r * 4), r == 0 ? s & msk[0] : s);
            rdc(8'(c * 32 + r * 4), s & msk[r]);
         end
      end
      avs_byteenable_i <= 4'h3;
      bus(1'b1, 8'h68, 32'h0000_0000);
      avs_byteenable_i <= 4'hF;
      rdc(8'h68, s);
      // Known peripheral pointer on the first three channels
      pa = 16'(rnd());
      for (int c = 0; c < 3; c++) bus(1'b1, 8'(c * 32 + 16), {16'h0000, pa});
      // Continuous word block from RAM to peripheral, prompt far side
      dir <= 1'b1;
      s = rnd();
      bus(1'b1, 8'h08, s);
      bus(1'b1, 8'h04, 32'h0000_0000);
      bus(1'b1, 8'h14, 32'h0000_0003);
      bus(1'b1, 8'h98, 32'h0000_0001);
      bus(1'b1, 8'h00, 32'h0000_A000);
      for (int i = 0; i < 4; i++) xfer(0);
      rdc(8'h94, 32'h0000_0001);
      cmp(32'(irq_o), 32'h0000_0001);
      rdc(8'h90, ram_end(s, 32'h3, 1'b1, 1'b0));
      rdc(8'h00, 32'h0000_A000);
      rdc(8'h8C, 32'h0000_0000);
      bus(1'b1, 8'h94, 32'h0000_0001);
      cmp(32'(irq_o), 32'h0000_0000);
      bus(1'b1, 8'h00, 32'h0000_0000);
      // One-shot ping-pong bytes with null writes and half interrupt, slow far side
      slow <= 1'b1;
      dir <= 1'b0;
      byt <= 1'b1;
      nul <= 1'b1;
      s = rnd();
      bus(1'b1, 8'h2C, s);
      bus(1'b1, 8'h24, 32'h0000_0005);
      bus(1'b1, 8'h34, 32'h0000_0001);
      bus(1'b1, 8'h98, 32'h0000_0002);
      bus(1'b1, 8'h20, 32'h0000_D813);
      xfer(5);
      rdc(8'h94, 32'h0000_0002);
      bus(1'b1, 8'h94, 32'h0000_0002);
      for (int i = 0; i < 3; i++) xfer(5);
      rdc(8'h90, ram_end(s, 32'h1, 1'b0, 1'b1));
      rdc(8'h20, 32'h0000_5813);
      rdc(8'h8C, 32'h0000_0001);
      // One-shot single byte transfer from peripheral to RAM, no ping-pong
      bus(1'b1, 8'h48, s);
      bus(1'b1, 8'h44, 32'h0000_0002);
      bus(1'b1, 8'h54, 32'h0000_0000);
      bus(1'b1, 8'h40, 32'h0000_C001);
      xfer(2);
      rdc(8'h40, 32'h0000_4001);
      rdc(8'h94, 32'h0000_0006);
      rdc(8'h90, s);
      rdc(8'h8C, 32'h0000_0002);
      complete_run();
   end
endmodule : test_dma_channel_control

// File: verilog/dcc_cfg.svh
// Register offsets, field positions, masks and reset values of the DMA channel block
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH
// ----------------------------------------------------------------------------
// Per-channel register window
// ----------------------------------------------------------------------------
`define DCC_CH_STRIDE 8'h20
`define DCC_OFF_CTRL 8'h00
`define DCC_OFF_REQ 8'h04
`define DCC_OFF_STA 8'h08
`define DCC_OFF_STB 8'h0C
`define DCC_OFF_PAD 8'h10
`define DCC_OFF_CNT 8'h14
// ----------------------------------------------------------------------------
// Common registers
// ----------------------------------------------------------------------------
`define DCC_OFF_PWC 8'h80
`define DCC_OFF_RQC 8'h84
`define DCC_OFF_PPS 8'h88
`define DCC_OFF_LCA 8'h8C
`define DCC_OFF_LRA 8'h90
`define DCC_OFF_IFLAG 8'h94
`define DCC_OFF_IEN 8'h98
`define DCC_OFF_IPRI 8'h9C
// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define DCC_B_ON 15
`define DCC_B_BYTE 14
`define DCC_B_DIR 13
`define DCC_B_HALF 12
`define DCC_B_NULL 11
`define DCC_B_AM_HI 5
`define DCC_B_AM_LO 4
`define DCC_B_MD_HI 1
`define DCC_B_MD_LO 0
`define DCC_CTRL_MASK 16'hF833
`define DCC_CTRL_RST 16'h0000
`define DCC_REQ_MASK 16'h00FF
`define DCC_CNT_MASK 14'h3FFF
`define DCC_IPRI_RST 16'h4444
`define DCC_LCA_IDLE 4'hF
`define DCC_UNMAPPED 32'h0000_0000
`endif

// File: verilog/dcc_chan.sv
// One DMA channel: configuration registers and block sequencing
`timescale 1ns/1ps
`include "dcc_cfg.svh"
module dcc_chan (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic wr_i,
   input wire logic [2:0] reg_i,
   input wire logic [31:0] wdata_i,
   input wire logic xfer_done_i,
   output logic [15:0] ctrl_o,
   output logic [15:0] req_o,
   output logic [31:0] sta_o,
   output logic [31:0] stb_o,
   output logic [15:0] pad_o,
   output logic [13:0] cnt_o,
   output logic [31:0] ram_addr_o,
   output logic [13:0] done_o,
   output logic pp_o,
   output logic blk_irq_o
);
   logic [15:0] ctrl_r, ctrl_nxt;
   logic [15:0] req_r, req_nxt;
   logic [31:0] sta_r, sta_nxt, stb_r, stb_nxt;
   logic [15:0] pad_r, pad_nxt;
   logic [13:0] cnt_r, cnt_nxt, done_r, done_nxt;
   logic [31:0] addr_r, addr_nxt;
   logic pp_r, pp_nxt, irq_r, irq_nxt;
   logic [13:0] half_pt;
   logic last;
   logic pingpong;
   logic oneshot;
   dcc_pkg::dcc_addressing_scheme_e am;

   // ----------------------------------------------------------------------------
   // Next-state of configuration and progress
   // ----------------------------------------------------------------------------
   always_comb begin
      ctrl_nxt = ctrl_r;
      req_nxt = req_r;
      sta_nxt = sta_r;
      stb_nxt = stb_r;
      pad_nxt = pad_r;
      cnt_nxt = cnt_r;
      done_nxt = done_r;
      addr_nxt = addr_r;
      pp_nxt = pp_r;
      irq_nxt = 1'b0;
      am = dcc_pkg::dcc_addressing_scheme_e'(ctrl_r[`DCC_B_AM_HI:`DCC_B_AM_LO]);
      pingpong = ctrl_r[`DCC_B_MD_HI];
      oneshot = ctrl_r[`DCC_B_MD_LO];
      // Count register holds transfers minus one
      half_pt = {1'b0, cnt_r[13:1]};
      last = (done_r == cnt_r);
      if (xfer_done_i && ctrl_r[`DCC_B_ON]) begin
         // Word or byte step, no step without post-increment
         if (am == dcc_pkg::DCC_AM_POSTINC) begin
            addr_nxt = addr_r + (ctrl_r[`DCC_B_BYTE] ? 32'h0000_0001 : 32'h0000_0002);
         end
         if (ctrl_r[`DCC_B_HALF] && done_r == half_pt) begin
            irq_nxt = 1'b1;
         end
         if (last) begin
            irq_nxt = irq_nxt | ~ctrl_r[`DCC_B_HALF];
            done_nxt = 14'h0000;
            if (pingpong) begin
               pp_nxt = ~pp_r;
               addr_nxt = pp_r ? sta_r : stb_r;
            end else begin
               addr_nxt = sta_r;
            end
            // One-shot stops after one block, or after both buffers in ping-pong
            if (oneshot && (!pingpong || pp_r)) begin
               ctrl_nxt[`DCC_B_ON] = 1'b0;
               pp_nxt = 1'b0;
            end
         end else begin
            done_nxt = done_r + 14'h0001;
         end
      end
      // Software writes override progress updates
      if (wr_i) begin
         unique case (reg_i)
            3'd0: begin
               ctrl_nxt = wdata_i[15:0] & `DCC_CTRL_MASK;
               if (wdata_i[`DCC_B_ON] && !ctrl_r[`DCC_B_ON]) begin
                  done_nxt = 14'h0000;
                  pp_nxt = 1'b0;
                  addr_nxt = sta_r;
               end
            end
            3'd1: req_nxt = wdata_i[15:0] & `DCC_REQ_MASK;
            3'd2: sta_nxt = wdata_i;
            3'd3: stb_nxt = wdata_i;
            3'd4: pad_nxt = wdata_i[15:0];
            3'd5: cnt_nxt = wdata_i[13:0] & `DCC_CNT_MASK;
            default: ;
         endcase
      end
   end

   // Register stage
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_r <= `DCC_CTRL_RST;
         req_r <= 16'h0000;
         sta_r <= 32'h0000_0000;
         stb_r <= 32'h0000_0000;
         pad_r <= 16'h0000;
         cnt_r <= 14'h0000;
         done_r <= 14'h0000;
         addr_r <= 32'h0000_0000;
         pp_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         req_r <= req_nxt;
         sta_r <= sta_nxt;
         stb_r <= stb_nxt;
         pad_r <= pad_nxt;
         cnt_r <= cnt_nxt;
         done_r <= done_nxt;
         addr_r <= addr_nxt;
         pp_r <= pp_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign ctrl_o = ctrl_r;
   assign req_o = req_r;
   assign sta_o = sta_r;
   assign stb_o = stb_r;
   assign pad_o = pad_r;
   assign cnt_o = cnt_r;
   assign ram_addr_o = addr_r;
   assign done_o = done_r;
   assign pp_o = pp_r;
   assign blk_irq_o = irq_r;
endmodule : dcc_chan

// File: verilog/dcc_pkg.sv
// Types of the DMA channel block
package dcc_pkg;
   typedef enum logic [1:0] {
      DCC_AM_POSTINC = 2'b00,
      DCC_AM_NOINC = 2'b01,
      DCC_AM_PERIPH = 2'b10,
      DCC_AM_RSVD = 2'b11
   } dcc_addressing_scheme_e;
   typedef enum logic [1:0] {
      DCC_MD_CONT = 2'b00,
      DCC_MD_ONESHOT = 2'b01,
      DCC_MD_CONT_PP = 2'b10,
      DCC_MD_ONESHOT_PP = 2'b11
   } dcc_mode_e;
   typedef enum logic [1:0] {
      DCC_ST_IDLE = 2'b00,
      DCC_ST_READ = 2'b01,
      DCC_ST_WRITE = 2'b10,
      DCC_ST_NULL = 2'b11
   } dcc_xfer_e;
endpackage : dcc_pkg

// File: verilog/dcc_top.sv
// Four-channel DMA controller: register slave, arbitration and transfer engine
// ----------------------------------------------------------------------------
// Notes on behaviour
// - Four independent channels 0..3, each with its own six registers.
// - Control, request select and peripheral address registers are 16 bits.
// - Primary and secondary RAM start addresses are 32-bit registers.
// - A 14-bit transfer count sets the transfers per block.
// - Shared status: write collisions, request collisions, last address, last channel.
// - Channel interrupt flag, enable and priority live in interrupt registers.
// - Control bit 15 enables the channel when set.
// - Control bit 14 selects byte transfers, else word transfers.
// - Bit 13 set reads RAM, writes peripheral; clear reads peripheral, writes RAM.
// - Bit 12 raises block interrupt at half block, else at full block.
// - Bit 11 with bit 13 clear adds a null peripheral write.
// - Bits 5-4 pick post-increment, no increment, or peripheral indirect.
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`include "dcc_cfg.svh"
module dcc_top (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [7:0] periph_req_i,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic mem_periph_o,
   output logic [31:0] mem_addr_o,
   output logic [15:0] mem_wdata_o,
   output logic mem_byte_o,
   input wire logic mem_ack_i,
   input wire logic [15:0] mem_rdata_i,
   output logic irq_o
);
   // ----------------------------------------------------------------------------
   // Channel instances
   // ----------------------------------------------------------------------------
   logic [15:0] ctrl [4];
   logic [15:0] reqs [4];
   logic [31:0] sta [4];
   logic [31:0] stb [4];
   logic [15:0] pad [4];
   logic [13:0] cnt [4];
   logic [31:0] raddr [4];
   logic [13:0] done [4];
   logic [3:0] pp;
   logic [3:0] blk_irq;
   logic [3:0] ch_wr;
   logic [3:0] ch_done;
   logic [2:0] reg_sel;
   logic bus_wr;
   logic full_word;

   assign full_word = (avs_byteenable_i == 4'hF);
   assign bus_wr = avs_write_i & ~avs_waitrequest_o & full_word;
   assign reg_sel = avs_address_i[4:2];

   // Four identical channels each own their register set
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_ch
         assign ch_wr[g] = bus_wr && avs_address_i[7] == 1'b0 && avs_address_i[6:5] == 2'(g);
         dcc_chan u_chan (
            .clk_i(clk_i),
            .rstn_i(rstn_i),
            .wr_i(ch_wr[g]),
            .reg_i(reg_sel),
            .wdata_i(avs_writedata_i),
            .xfer_done_i(ch_done[g]),
            .ctrl_o(ctrl[g]),
            .req_o(reqs[g]),
            .sta_o(sta[g]),
            .stb_o(stb[g]),
            .pad_o(pad[g]),
            .cnt_o(cnt[g]),
            .ram_addr_o(raddr[g]),
            .done_o(done[g]),
            .pp_o(pp[g]),
            .blk_irq_o(blk_irq[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------------
   // Request capture and arbitration
   // ----------------------------------------------------------------------------
   logic [3:0] pend_r, pend_nxt;
   logic [3:0] rqc_r, rqc_nxt;
   logic [3:0] pwc_r, pwc_nxt;
   logic [3:0] hit;
   logic [1:0] cur_r, cur_nxt;
   logic [3:0] lca_r, lca_nxt;
   logic [31:0] lra_r, lra_nxt;
   logic [15:0] data_r, data_nxt;
   logic [3:0] iflag_r, iflag_nxt;
   logic [3:0] ien_r, ien_nxt;
   logic [15:0] ipri_r, ipri_nxt;
   dcc_pkg::dcc_xfer_e st_r, st_nxt;
   logic grant;
   logic [1:0] pick;
   logic to_periph;
   logic clr_pwc, clr_rqc, clr_if;

   // A channel sees its selected request line when enabled
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         hit[i] = ctrl[i][`DCC_B_ON] & periph_req_i[reqs[i][2:0]];
      end
   end

   // Lowest-numbered pending channel wins
   always_comb begin
      grant = 1'b0;
      pick = 2'd0;
      for (int i = 3; i >= 0; i--) begin
         if (pend_r[i]) begin
            grant = 1'b1;
            pick = 2'(i);
         end
      end
   end

   assign clr_pwc = bus_wr && avs_address_i == `DCC_OFF_PWC;
   assign clr_rqc = bus_wr && avs_address_i == `DCC_OFF_RQC;
   assign clr_if = bus_wr && avs_address_i == `DCC_OFF_IFLAG;

   // ----------------------------------------------------------------------------
   // Transfer engine next state
   // ----------------------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      cur_nxt = cur_r;
      lca_nxt = lca_r;
      lra_nxt = lra_r;
      data_nxt = data_r;
      ch_done = 4'h0;
      to_periph = ctrl[cur_r][`DCC_B_DIR];
      pend_nxt = pend_r;
      rqc_nxt = rqc_r;
      pwc_nxt = pwc_r;
      if (clr_rqc) begin
         rqc_nxt = rqc_r & ~avs_writedata_i[3:0];
      end
      if (clr_pwc) begin
         pwc_nxt = pwc_r & ~avs_writedata_i[3:0];
      end
      unique case (st_r)
         dcc_pkg::DCC_ST_IDLE: begin
            if (grant) begin
               cur_nxt = pick;
               pend_nxt[pick] = 1'b0;
               st_nxt = dcc_pkg::DCC_ST_READ;
            end
         end
         dcc_pkg::DCC_ST_READ: begin
            if (mem_ack_i) begin
               data_nxt = mem_rdata_i;
               st_nxt = dcc_pkg::DCC_ST_WRITE;
            end
         end
         dcc_pkg::DCC_ST_WRITE: begin
            if (mem_ack_i) begin
               lca_nxt = {2'b00, cur_r};
               lra_nxt = raddr[cur_r];
               if (ctrl[cur_r][`DCC_B_NULL] && !to_periph) begin
                  st_nxt = dcc_pkg::DCC_ST_NULL;
               end else begin
                  ch_done[cur_r] = 1'b1;
                  st_nxt = dcc_pkg::DCC_ST_IDLE;
               end
            end
         end
         dcc_pkg::DCC_ST_NULL: begin
            if (mem_ack_i) begin
               ch_done[cur_r] = 1'b1;
               st_nxt = dcc_pkg::DCC_ST_IDLE;
            end
         end
      endcase
      // New requests: a repeat while still pending is a collision, set beats clear
      for (int i = 0; i < 4; i++) begin
         if (hit[i]) begin
            if (pend_nxt[i]) begin
               rqc_nxt[i] = 1'b1;
            end
            pend_nxt[i] = 1'b1;
         end
         // Software touching a channel mid-transfer marks a write collision
         if (ch_wr[i] && st_r != dcc_pkg::DCC_ST_IDLE && cur_r == 2'(i)) begin
            pwc_nxt[i] = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Channel interrupt flag, enable and priority registers
   // ----------------------------------------------------------------------------
   always_comb begin
      iflag_nxt = iflag_r;
      ien_nxt = ien_r;
      ipri_nxt = ipri_r;
      if (clr_if) begin
         iflag_nxt = iflag_r & ~avs_writedata_i[3:0];
      end
      iflag_nxt = iflag_nxt | blk_irq;
      if (bus_wr && avs_address_i == `DCC_OFF_IEN) begin
         ien_nxt = avs_writedata_i[3:0];
      end
      if (bus_wr && avs_address_i == `DCC_OFF_IPRI) begin
         ipri_nxt = avs_writedata_i[15:0] & 16'h7777;
      end
   end

   // Register stage of the shared state
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r <= dcc_pkg::DCC_ST_IDLE;
         cur_r <= 2'd0;
         pend_r <= 4'h0;
         rqc_r <= 4'h0;
         pwc_r <= 4'h0;
         lca_r <= `DCC_LCA_IDLE;
         lra_r <= 32'h0000_0000;
         data_r <= 16'h0000;
         iflag_r <= 4'h0;
         ien_r <= 4'h0;
         ipri_r <= `DCC_IPRI_RST;
      end else begin
         st_r <= st_nxt;
         cur_r <= cur_nxt;
         pend_r <= pend_nxt;
         rqc_r <= rqc_nxt;
         pwc_r <= pwc_nxt;
         lca_r <= lca_nxt;
         lra_r <= lra_nxt;
         data_r <= data_nxt;
         iflag_r <= iflag_nxt;
         ien_r <= ien_nxt;
         ipri_r <= ipri_nxt;
      end
   end

   // ----------------------------------------------------------------------------
   // Memory-side request signals
   // ----------------------------------------------------------------------------
   // Read phase uses the source bus, write phase the destination bus
   always_comb begin
      mem_req_o = (st_r != dcc_pkg::DCC_ST_IDLE);
      mem_we_o = (st_r == dcc_pkg::DCC_ST_WRITE) || (st_r == dcc_pkg::DCC_ST_NULL);
      mem_byte_o = ctrl[cur_r][`DCC_B_BYTE];
      mem_wdata_o = (st_r == dcc_pkg::DCC_ST_NULL) ? 16'h0000 : data_r;
      mem_periph_o = 1'b0;
      if (st_r == dcc_pkg::DCC_ST_READ) begin
         mem_periph_o = ~to_periph;
      end else if (st_r == dcc_pkg::DCC_ST_WRITE) begin
         mem_periph_o = to_periph;
      end else if (st_r == dcc_pkg::DCC_ST_NULL) begin
         mem_periph_o = 1'b1;
      end
      if (mem_periph_o) begin
         mem_addr_o = {16'h0000, pad[cur_r]};
      end else if (ctrl[cur_r][`DCC_B_AM_HI:`DCC_B_AM_LO] == dcc_pkg::DCC_AM_PERIPH) begin
         // Peripheral indirect: the peripheral supplies the offset
         mem_addr_o = (pp[cur_r] ? stb[cur_r] : sta[cur_r]) + {16'h0000, data_r};
      end else begin
         mem_addr_o = raddr[cur_r];
      end
   end

   assign irq_o = |(iflag_r & ien_r);

   // ----------------------------------------------------------------------------
   // Avalon read mux, one wait state
   // ----------------------------------------------------------------------------
   logic [31:0] rd_nxt;
   logic [31:0] rd_r;
   logic [1:0] rch;
   assign rch = avs_address_i[6:5];
   always_comb begin
      rd_nxt = `DCC_UNMAPPED;
      if (avs_address_i[7] == 1'b0) begin
         unique case (reg_sel)
            3'd0: rd_nxt = {16'h0000, ctrl[rch]};
            3'd1: rd_nxt = {16'h0000, reqs[rch]};
            3'd2: rd_nxt = sta[rch];
            3'd3: rd_nxt = stb[rch];
            3'd4: rd_nxt = {16'h0000, pad[rch]};
            3'd5: rd_nxt = {18'h0_0000, cnt[rch]};
            3'd6: rd_nxt = {18'h0_0000, done[rch]};
            default: rd_nxt = `DCC_UNMAPPED;
         endcase
      end else begin
         unique case (avs_address_i)
            `DCC_OFF_PWC: rd_nxt = {28'h000_0000, pwc_r};
            `DCC_OFF_RQC: rd_nxt = {28'h000_0000, rqc_r};
            `DCC_OFF_PPS: rd_nxt = {28'h000_0000, pp};
            `DCC_OFF_LCA: rd_nxt = {28'h000_0000, lca_r};
            `DCC_OFF_LRA: rd_nxt = lra_r;
            `DCC_OFF_IFLAG: rd_nxt = {28'h000_0000, iflag_r};
            `DCC_OFF_IEN: rd_nxt = {28'h000_0000, ien_r};
            `DCC_OFF_IPRI: rd_nxt = {16'h0000, ipri_r};
            default: rd_nxt = `DCC_UNMAPPED;
         endcase
      end
   end

   // Read data registered; request held one cycle by waitrequest
   logic rd_ph_r, rd_ph_nxt;
   always_comb begin
      rd_ph_nxt = (avs_read_i || avs_write_i) && !rd_ph_r;
   end
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_ph_r <= 1'b0;
         rd_r <= 32'h0000_0000;
      end else begin
         rd_ph_r <= rd_ph_nxt;
         rd_r <= rd_nxt;
      end
   end
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !rd_ph_r;
   assign avs_readdata_o = rd_r;
endmodule : dcc_top
